// ===== dv/io_space_decoder_gp_regs_tb.sv
// Self-checking bench of the I/O space decoder
`timescale 1ns/100ps
module io_space_decoder_gp_regs_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] flag_set = 8'h00;
	logic [7:0] ext_ctrl, flag_out;
	iod_pkg::iod_req_s req;
	iod_pkg::iod_rsp_s rsp, a;
	int n_fail = 0;
	int tests_run = 0;
	always #5 clk = ~clk;
	iod_decoder i_dut (.clk(clk), .rst(rst), .req(req), .flag_set(flag_set), .rsp(rsp),
		.ext_ctrl(ext_ctrl), .flag_out(flag_out));
	iod_core_model i_core (.clk(clk), .rsp(rsp), .req(req));
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic acc(input iod_pkg::iod_op_e op, input logic wr, input logic [7:0] ad,
		input logic [7:0] wd, input logic [2:0] bs = 3'h0, input logic bv = 1'b0,
		input logic sh = 1'b0);
		i_core.issue({1'b1, op, wr, ad, wd, bs, bv, sh}, a);
		chk1(a.valid, 1'b1);
		repeat (2) @(posedge clk);
	endtask
	task automatic t_reset;
		acc(iod_pkg::IOD_OP_PORT, 1'b0, 8'h1E, 8'h00);
		chk8(a.rdata, 8'h00);
		acc(iod_pkg::IOD_OP_DATA, 1'b0, 8'h4A, 8'h00);
		chk8(a.rdata, 8'h00);
		acc(iod_pkg::IOD_OP_PORT, 1'b0, 8'h2B, 8'h00);
		chk8(a.rdata, 8'h00);
		chk8(flag_out, 8'h00);
		$display("t_reset done");
	endtask
	task automatic t_scratch;
		acc(iod_pkg::IOD_OP_PORT, 1'b1, 8'h1E, 8'hA5);
		acc(iod_pkg::IOD_OP_DATA, 1'b0, 8'h3E, 8'h00);
		chk8(a.rdata, 8'hA5);
		acc(iod_pkg::IOD_OP_DATA, 1'b1, 8'h4B, 8'h3C);
		acc(iod_pkg::IOD_OP_PORT, 1'b0, 8'h2B, 8'h00);
		chk8(a.rdata, 8'h3C);
		acc(iod_pkg::IOD_OP_PORT, 1'b1, 8'h2A, 8'hFF);
		acc(iod_pkg::IOD_OP_DATA, 1'b0, 8'h4A, 8'h00);
		chk8(a.rdata, 8'hFF);
		$display("t_scratch done");
	endtask
	task automatic t_bits;
		acc(iod_pkg::IOD_OP_BIT, 1'b1, 8'h1E, 8'h00, 3'h6, 1'b1);
		acc(iod_pkg::IOD_OP_PORT, 1'b0, 8'h1E, 8'h00);
		chk8(a.rdata, 8'hE5);
		acc(iod_pkg::IOD_OP_BIT, 1'b0, 8'h1E, 8'h00, 3'h6, 1'b0, 1'b1);
		chk1(a.skip, 1'b1);
		acc(iod_pkg::IOD_OP_BIT, 1'b0, 8'h1E, 8'h00, 3'h4, 1'b0, 1'b1);
		chk1(a.skip, 1'b0);
		acc(iod_pkg::IOD_OP_BIT, 1'b1, 8'h1E, 8'h00, 3'h0, 1'b0);
		acc(iod_pkg::IOD_OP_PORT, 1'b0, 8'h1E, 8'h00);
		chk8(a.rdata, 8'hE4);
		$display("t_bits done");
	endtask
	task automatic t_flags;
		flag_set <= 8'h07;
		@(posedge clk);
		flag_set <= 8'h00;
		repeat (3) @(posedge clk);
		chk8(flag_out, 8'h07);
		acc(iod_pkg::IOD_OP_PORT, 1'b1, 8'h15, 8'h00);
		chk8(flag_out, 8'h07);
		acc(iod_pkg::IOD_OP_PORT, 1'b1, 8'h15, 8'h01);
		chk8(flag_out, 8'h06);
		acc(iod_pkg::IOD_OP_BIT, 1'b1, 8'h15, 8'h00, 3'h2, 1'b1);
		chk8(flag_out, 8'h02);
		acc(iod_pkg::IOD_OP_BIT, 1'b1, 8'h15, 8'h00, 3'h1, 1'b0);
		chk8(flag_out, 8'h02);
		// Event held across a write-one clear of the same flag
		flag_set <= 8'h01;
		acc(iod_pkg::IOD_OP_PORT, 1'b1, 8'h15, 8'h01);
		flag_set <= 8'h00;
		chk8(flag_out, 8'h03);
		$display("t_flags done");
	endtask
	task automatic t_miss;
		acc(iod_pkg::IOD_OP_PORT, 1'b0, 8'h40, 8'h00);
		chk1(a.miss, 1'b1);
		chk8(a.rdata, 8'h00);
		acc(iod_pkg::IOD_OP_BIT, 1'b0, 8'h2A, 8'h00, 3'h0, 1'b0, 1'b1);
		chk1(a.miss, 1'b1);
		acc(iod_pkg::IOD_OP_DATA, 1'b1, 8'h60, 8'h5A);
		chk8(ext_ctrl, 8'h5A);
		acc(iod_pkg::IOD_OP_DATA, 1'b0, 8'h60, 8'h00);
		chk8(a.rdata, 8'h5A);
		acc(iod_pkg::IOD_OP_PORT, 1'b0, 8'h60, 8'h00);
		chk1(a.miss, 1'b1);
		$display("t_miss done");
	endtask
	task automatic t_rereset;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk8(flag_out, 8'h00);
		chk8(ext_ctrl, 8'h00);
		acc(iod_pkg::IOD_OP_PORT, 1'b0, 8'h1E, 8'h00);
		chk8(a.rdata, 8'h00);
		$display("t_rereset done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_scratch();
		t_bits();
		t_flags();
		t_miss();
		t_rereset();
		end_of_test();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#20000;
		n_fail++;
		end_of_test();
	end
endmodule

// ===== dv/iod_core_model.sv
// Core-side model that issues one-cycle requests and collects the answer
`timescale 1ns/100ps
module iod_core_model (
	input wire logic clk,
	input wire iod_pkg::iod_rsp_s rsp,
	output iod_pkg::iod_req_s req
);
	initial begin
		req = '0;
	end
	// Writes go to mapped places only; reserved spots are just read
	task automatic issue(input iod_pkg::iod_req_s r, output iod_pkg::iod_rsp_s a);
		int n;
		a = '0;
		n = 0;
		@(posedge clk);
		req <= r;
		@(posedge clk);
		// Released lines carry the inverse so a stale value never looks valid
		req <= iod_pkg::iod_req_s'({1'b0, ~r[$bits(iod_pkg::iod_req_s)-2:0]});
		while (n < 4 && a.valid !== 1'b1) begin
			@(posedge clk);
			#1;
			a = rsp;
			n++;
		end
	endtask
endmodule

// ===== rtl/iod_decoder.sv
// I/O space decoder with scratch registers, flag register and extended register
`timescale 1ns/100ps
`include "iod_map.svh"
// Operation
// - Locations at port addresses 0x00..0x1F accept single-bit set and clear of one bit.
// - Locations at 0x00..0x1F answer a bit test that tells the core to skip.
// - Port accesses use addresses 0x00..0x3F, 64 locations.
// - A data access reaches each port location at its port address plus 0x20.
// - Every I/O location is reachable by data-space loads and stores.
// - Data addresses 0x60..0xFF are reachable only by data accesses.
// - Status flags clear on a written one and keep their value on a written zero.
// - Bit set or clear touches only its bit, so other flags are not cleared.
// - Three 8-bit scratch registers hold any value and reset to zero.
// - A scratch register in the low range also takes bit set, clear and test.
module iod_decoder (
	input wire logic clk,
	input wire logic rst,
	input wire iod_pkg::iod_req_s req,
	input wire logic [7:0] flag_set,
	output iod_pkg::iod_rsp_s rsp,
	output logic [7:0] ext_ctrl,
	output logic [7:0] flag_out
);
	logic [7:0] flag_reg;
	logic [7:0] flag_next;
	logic [7:0] ext_reg;
	logic [7:0] scr_rd;
	logic [23:0] scr_all;
	logic [7:0] cur_val;
	logic [7:0] bit_mask;
	logic [7:0] wr_val;
	logic [7:0] rd_hold_reg;
	logic use_scr_reg;
	logic rsp_valid_reg;
	logic skip_reg;
	logic miss_reg;

	// Normalise every request to a port address or an extended address
	wire is_port = req.op == iod_pkg::IOD_OP_PORT;
	wire is_bit = req.op == iod_pkg::IOD_OP_BIT;
	wire is_data = req.op == iod_pkg::IOD_OP_DATA;
	wire port_ok = (is_port || is_bit) && req.addr <= {2'b00, `IOD_PORT_TOP};
	wire bit_ok = is_bit && req.addr <= {2'b00, `IOD_BIT_TOP};
	wire data_io = is_data && req.addr >= `IOD_DATA_OFS && req.addr <= `IOD_DATA_IO_TOP;
	wire data_ext = is_data && req.addr >= `IOD_EXT_LO;
	wire [7:0] data_io_addr = req.addr - `IOD_DATA_OFS;
	wire [5:0] io_addr = data_io ? data_io_addr[5:0] : req.addr[5:0];
	wire io_hit = (is_port && port_ok) || bit_ok || data_io;
	wire hit_s0 = io_hit && io_addr == `IOD_SCR0_ADDR;
	wire hit_s1 = io_hit && io_addr == `IOD_SCR1_ADDR;
	wire hit_s2 = io_hit && io_addr == `IOD_SCR2_ADDR;
	wire hit_flg = io_hit && io_addr == `IOD_W1C_ADDR;
	wire hit_ext = data_ext && req.addr == `IOD_EXT_ADDR;
	wire hit_any = hit_s0 || hit_s1 || hit_s2 || hit_flg || hit_ext;
	wire bit_req = req.valid && bit_ok && hit_any;
	wire do_wr = req.valid && hit_any && (req.write || (bit_req && !req.skip_high));
	wire [1:0] scr_sel = hit_s1 ? `IOD_SEL_SCR1 : (hit_s2 ? `IOD_SEL_SCR2 : `IOD_SEL_SCR0);

	assign bit_mask = `IOD_BIT_ONE << req.bit_sel;
	assign cur_val = hit_s0 ? scr_all[7:0] : hit_s1 ? scr_all[15:8] :
		hit_s2 ? scr_all[23:16] : hit_flg ? flag_reg : hit_ext ? ext_reg : `IOD_ZERO8;
	// A bit op on a scratch register rewrites only the chosen bit
	assign wr_val = bit_req ? (req.bit_val ? (cur_val | bit_mask) : (cur_val & ~bit_mask))
		: req.wdata;
	wire bit_test = |(cur_val & bit_mask);

	iod_scratch_bank #(.NREG(3)) u_bank (
		.clk(clk),
		.rst(rst),
		.wr_en({do_wr && hit_s2, do_wr && hit_s1, do_wr && hit_s0}),
		.wr_data(wr_val),
		.rd_sel(scr_sel),
		.rd_data(scr_rd),
		.all_data(scr_all)
	);

	// Flag clear: a plain write clears ones; a bit op clears only its bit so siblings survive
	wire [7:0] clr_mask = !(do_wr && hit_flg) ? `IOD_ZERO8 :
		bit_req ? (req.bit_val ? bit_mask : `IOD_ZERO8) : req.wdata;
	// Hardware set wins over a same-cycle clear
	assign flag_next = (flag_reg & ~clr_mask) | flag_set;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flag_reg <= `IOD_ZERO8;
			ext_reg <= `IOD_EXT_RST;
		end else begin
			flag_reg <= flag_next;
			if (do_wr && hit_ext)
				ext_reg <= req.wdata;
		end
	end

	// Answer two cycles after the request; misses read zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_valid_reg <= 1'b0;
			skip_reg <= 1'b0;
			miss_reg <= 1'b0;
			use_scr_reg <= 1'b0;
			rd_hold_reg <= `IOD_ZERO8;
		end else begin
			rsp_valid_reg <= req.valid;
			skip_reg <= req.valid && bit_ok && (bit_test == req.skip_high) && !req.write;
			miss_reg <= req.valid && !hit_any;
			use_scr_reg <= hit_s0 || hit_s1 || hit_s2;
			rd_hold_reg <= (req.valid && hit_any) ? cur_val : `IOD_ZERO8;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp <= '0;
			ext_ctrl <= `IOD_EXT_RST;
			flag_out <= `IOD_ZERO8;
		end else begin
			rsp.valid <= rsp_valid_reg;
			rsp.rdata <= use_scr_reg ? scr_rd : rd_hold_reg;
			rsp.skip <= skip_reg;
			rsp.miss <= miss_reg;
			ext_ctrl <= ext_reg;
			flag_out <= flag_reg;
		end
	end

	chk_flag_set_wins: assert property (@(posedge clk) disable iff (rst)
		flag_set[0] |=> flag_reg[0]) else $error("flag set lost");
	chk_zero_keeps_flag: assert property (@(posedge clk) disable iff (rst)
		(req.valid && req.op == iod_pkg::IOD_OP_PORT && req.write && hit_flg
		&& !req.wdata[0] && flag_reg[0]) |=> flag_reg[0]) else $error("zero cleared flag");
	chk_bit_only_one: assert property (@(posedge clk) disable iff (rst)
		(bit_req && hit_flg && req.bit_sel != 3'h1 && flag_reg[1]) |=> flag_reg[1])
		else $error("bit op cleared sibling");
	chk_ext_port_miss: assert property (@(posedge clk) disable iff (rst)
		(req.valid && !is_data && req.write) |=> ext_reg == $past(ext_reg))
		else $error("extended reached by port");
	chk_miss_reads_zero: assert property (@(posedge clk) disable iff (rst)
		(req.valid && !hit_any) |-> ##2 (rsp.valid && rsp.miss && rsp.rdata == `IOD_ZERO8))
		else $error("miss not zero");
	chk_alias_same: assert property (@(posedge clk) disable iff (rst)
		(req.valid && is_data && req.addr == `IOD_DATA_OFS + {2'b00, `IOD_SCR0_ADDR})
		|-> hit_s0) else $error("data alias broken");
	chk_high_bit_none: assert property (@(posedge clk) disable iff (rst)
		(req.valid && is_bit && req.addr > {2'b00, `IOD_BIT_TOP}) |-> !do_wr)
		else $error("bit op above low range");
	chk_scr_store: assert property (@(posedge clk) disable iff (rst)
		(req.valid && is_port && req.write && hit_s1) |=> scr_all[15:8] == $past(req.wdata))
		else $error("scratch not stored");
	chk_skip_test: assert property (@(posedge clk) disable iff (rst)
		(bit_req && !req.write && req.skip_high && bit_test) |-> ##2 rsp.skip)
		else $error("skip missed");
	chk_rsp_two_later: assert property (@(posedge clk) disable iff (rst)
		req.valid |-> ##2 rsp.valid) else $error("answer not two cycles late");
	chk_port_top_miss: assert property (@(posedge clk) disable iff (rst)
		(req.valid && is_port && req.addr > {2'b00, `IOD_PORT_TOP}) |-> ##2 rsp.miss)
		else $error("port above range answered");
	// Compares every bit except the chosen one, so a read-modify-write that slips on another bit is caught
	chk_bit_keeps_rest: assert property (@(posedge clk) disable iff (rst)
		(bit_req && hit_s0 && !req.skip_high) |=>
		((scr_all[7:0] ^ $past(scr_all[7:0])) & ~$past(bit_mask)) == `IOD_ZERO8)
		else $error("bit op touched other bits");
	chk_miss_no_write: assert property (@(posedge clk) disable iff (rst)
		(req.valid && !hit_any) |=> (scr_all == $past(scr_all) && ext_reg == $past(ext_reg)))
		else $error("miss changed a register");
endmodule

// ===== rtl/iod_map.svh
// Address map and field constants of the I/O space decoder
`ifndef IOD_MAP_SVH
`define IOD_MAP_SVH
`define IOD_PORT_TOP 6'h3F
`define IOD_BIT_TOP 6'h1F
`define IOD_DATA_OFS 8'h20
`define IOD_DATA_IO_TOP 8'h5F
`define IOD_EXT_LO 8'h60
`define IOD_EXT_HI 8'hFF
`define IOD_SCR0_ADDR 6'h1E
`define IOD_SCR1_ADDR 6'h2A
`define IOD_SCR2_ADDR 6'h2B
`define IOD_W1C_ADDR 6'h15
`define IOD_EXT_ADDR 8'h60
`define IOD_EXT_RST 8'h00
`define IOD_SCR_RST 8'h00
`define IOD_ZERO8 8'h00
`define IOD_SEL_SCR0 2'h0
`define IOD_SEL_SCR1 2'h1
`define IOD_SEL_SCR2 2'h2
`define IOD_BIT_ONE 8'h01
`endif

// ===== rtl/iod_pkg.sv
// Types of the I/O space decoder
package iod_pkg;
	typedef enum logic [1:0] {
		IOD_OP_PORT = 2'b00,
		IOD_OP_DATA = 2'b01,
		IOD_OP_BIT = 2'b10
	} iod_op_e;
	typedef struct packed {
		logic valid;
		iod_op_e op;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [2:0] bit_sel;
		logic bit_val;
		logic skip_high;
	} iod_req_s;
	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
		logic skip;
		logic miss;
	} iod_rsp_s;
endpackage

// ===== rtl/iod_scratch_bank.sv
// Bank of three scratch registers with read data from a register
`timescale 1ns/100ps
`include "iod_map.svh"
module iod_scratch_bank #(
	parameter int NREG = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [NREG-1:0] wr_en,
	input wire logic [7:0] wr_data,
	input wire logic [1:0] rd_sel,
	output logic [7:0] rd_data,
	output logic [NREG*8-1:0] all_data
);
	logic [7:0] mem_reg [NREG];
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_reg
			always_ff @(posedge clk or posedge rst) begin
				if (rst)
					mem_reg[gi] <= `IOD_SCR_RST;
				else if (wr_en[gi])
					mem_reg[gi] <= wr_data;
			end
			assign all_data[gi*8 +: 8] = mem_reg[gi];
		end
	endgenerate
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rd_data <= `IOD_ZERO8;
		else if (int'(rd_sel) < NREG)
			rd_data <= mem_reg[rd_sel];
		else
			rd_data <= `IOD_ZERO8;
	end
endmodule
